// file: core/sosc_pkg.sv
// Summary of operation
// - command 36h plus one parameter updates the scan-direction settings
// - bit 7 sets page order: 0 top to bottom, 1 bottom to top
// - bit 6 sets column order: 0 left to right, 1 right to left
// - bit 5: 0 normal ordering, 1 page and column roles exchanged
// - bit 4 sets refresh order: 0 top to bottom, 1 bottom to top
// - bit 3 sets color order: 0 red-green-blue, 1 blue-green-red
// - bits 1 and 0 hold horizontal and vertical flip; they are only stored, no logic flips the image
// - scan-direction command leaves all other mode state untouched
// - scan setting clears to 00h on hardware reset, kept on software reset
// - 37h takes two parameters: pointer bit 8 first, then bits 7 to 0
// - scroll pointer names the first displayed line of the scroll region
// - scroll origin is applied in the direction the refresh order bit picks
// - scroll-start accepted in normal mode and sleep, refused in partial mode
// - scroll pointer resets to 0000h on power-on, software and hardware reset
// - 38h without parameters leaves idle mode, restoring full color
// - idle-exit while not idle changes nothing
// - idle flag clears on power-on, software reset and hardware reset
// - while idle, each component shows only its most significant bit
// - bit 5 clear: column advances first, wraps and steps page; set: page first
package sosc_pkg;
   localparam logic [7:0] SOSC_CMD_SCAN = 8'h36;
   localparam logic [7:0] SOSC_CMD_SCROLL = 8'h37;
   localparam logic [7:0] SOSC_CMD_IDLE_EXIT = 8'h38;
   localparam logic [7:0] SOSC_CMD_IDLE_ENTER = 8'h39;
   localparam logic [7:0] SOSC_CMD_SW_RESET = 8'h01;
   localparam logic [7:0] SOSC_SCAN_RESET = 8'h00;
   localparam logic [8:0] SOSC_SCROLL_RESET = 9'h000;
   localparam int SOSC_BIT_PAGE_ORDER = 7;
   localparam int SOSC_BIT_COL_ORDER = 6;
   localparam int SOSC_BIT_EXCHANGE = 5;
   localparam int SOSC_BIT_REFRESH = 4;
   localparam int SOSC_BIT_BGR = 3;
   localparam int SOSC_BIT_HFLIP = 1;
   localparam int SOSC_BIT_VFLIP = 0;
   localparam int SOSC_PIX_W = 18;
   localparam int SOSC_COMP_W = 6;
   typedef enum logic [1:0] {SOSC_ST_IDLE, SOSC_ST_SCAN_P1, SOSC_ST_SCROLL_P1,
      SOSC_ST_SCROLL_P2} sosc_state_t;
endpackage : sosc_pkg

// file: core/sosc_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sosc_byte_if;
   logic valid;
   logic is_param;
   logic [7:0] data;
   modport src (output valid, output is_param, output data);
   modport dst (input valid, input is_param, input data);
endinterface : sosc_byte_if
`default_nettype wire

// file: core/sosc_strobe_capture.sv
`timescale 1ns/1ps
`default_nettype none
module sosc_strobe_capture
   import sosc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic write_strobe_n,
   input wire logic cmd_param_select,
   input wire logic [7:0] data_in,
   sosc_byte_if.src byte_o
);
   logic strobe_reg, strobe_next;
   logic valid_reg, valid_next;
   logic sel_reg, sel_next;
   logic [7:0] data_reg, data_next;

   always_comb begin
      strobe_next = write_strobe_n;
      valid_next = write_strobe_n && !strobe_reg;
      sel_next = valid_next ? cmd_param_select : sel_reg;
      data_next = valid_next ? data_in : data_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_reg <= 1'b1;
         valid_reg <= 1'b0;
         sel_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         strobe_reg <= strobe_next;
         valid_reg <= valid_next;
         sel_reg <= sel_next;
         data_reg <= data_next;
      end
   end

   assign byte_o.valid = valid_reg;
   assign byte_o.is_param = sel_reg;
   assign byte_o.data = data_reg;

   // captured byte one cycle after the rising edge
   edge_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
      (write_strobe_n && !$past(write_strobe_n)) |=> valid_reg && data_reg == $past(data_in))
      else $error("strobe edge not captured");
endmodule : sosc_strobe_capture
`default_nettype wire

// file: core/sosc_cmd_top.sv
`timescale 1ns/1ps
`default_nettype none
module sosc_cmd_top
   import sosc_pkg::*;
#(
   parameter int PAGES = 432,
   parameter int COLS = 240
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic write_strobe_n,
   input wire logic cmd_param_select,
   input wire logic [7:0] data_in,
   input wire logic partial_mode,
   input wire logic [SOSC_PIX_W-1:0] pixel_in,
   input wire logic pix_step,
   output logic [7:0] scan_ctrl,
   output logic [8:0] scroll_origin_line,
   output logic idle_mode,
   output logic [SOSC_PIX_W-1:0] pixel_out,
   output logic [8:0] page_addr,
   output logic [8:0] col_addr,
   output logic [8:0] first_panel_line
);
   initial begin
      if (PAGES < 2 || PAGES > 512 || COLS < 2 || COLS > 512)
         $error("page or column count unsupported");
   end

   localparam logic [8:0] LAST_PAGE = 9'(PAGES - 1);
   localparam logic [8:0] LAST_COL = 9'(COLS - 1);

   logic rs1_reg, rst_n;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rs1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_reg <= 1'b1;
         rst_n <= rs1_reg;
      end
   end

   sosc_byte_if bif ();
   sosc_strobe_capture u_cap (
      .clk(clk),
      .rst_n(rst_n),
      .write_strobe_n(write_strobe_n),
      .cmd_param_select(cmd_param_select),
      .data_in(data_in),
      .byte_o(bif.src)
   );

   function automatic logic [8:0] sosc_step(input logic [8:0] v, input logic down,
         input logic [8:0] last);
      if (down)
         sosc_step = (v == 9'h000) ? last : v - 9'h001;
      else
         sosc_step = (v == last) ? 9'h000 : v + 9'h001;
   endfunction : sosc_step

   sosc_state_t state_reg, state_next;
   logic [7:0] scan_reg, scan_next;
   logic [8:0] scroll_reg, scroll_next;
   logic hi_reg, hi_next;
   logic idle_reg, idle_next;
   logic is_cmd, is_par;

   assign is_cmd = bif.valid && !bif.is_param;
   assign is_par = bif.valid && bif.is_param;

   always_comb begin
      state_next = state_reg;
      scan_next = scan_reg;
      scroll_next = scroll_reg;
      hi_next = hi_reg;
      idle_next = idle_reg;
      if (is_cmd) begin
         state_next = SOSC_ST_IDLE;
         case (bif.data)
            SOSC_CMD_SCAN: state_next = SOSC_ST_SCAN_P1;
            SOSC_CMD_SCROLL: state_next = partial_mode ? SOSC_ST_IDLE : SOSC_ST_SCROLL_P1;
            // leave idle; no change if already off
            SOSC_CMD_IDLE_EXIT: idle_next = 1'b0;
            SOSC_CMD_IDLE_ENTER: idle_next = 1'b1;
            SOSC_CMD_SW_RESET: begin
               scroll_next = SOSC_SCROLL_RESET;
               idle_next = 1'b0;
            end
            default: state_next = SOSC_ST_IDLE;
         endcase
      end else if (is_par) begin
         case (state_reg)
            SOSC_ST_SCAN_P1: begin
               scan_next = bif.data;
               state_next = SOSC_ST_IDLE;
            end
            SOSC_ST_SCROLL_P1: begin
               hi_next = bif.data[0];
               state_next = SOSC_ST_SCROLL_P2;
            end
            SOSC_ST_SCROLL_P2: begin
               scroll_next = {hi_reg, bif.data};
               state_next = SOSC_ST_IDLE;
            end
            default: state_next = SOSC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SOSC_ST_IDLE;
         scan_reg <= SOSC_SCAN_RESET;
         scroll_reg <= SOSC_SCROLL_RESET;
         hi_reg <= 1'b0;
         idle_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         scan_reg <= scan_next;
         scroll_reg <= scroll_next;
         hi_reg <= hi_next;
         idle_reg <= idle_next;
      end
   end

   // derived display outputs, all registered
   logic [SOSC_PIX_W-1:0] pix_next, pix_reg;
   logic [8:0] page_reg, page_next, col_reg, col_next, first_reg, first_next;
   logic [SOSC_COMP_W-1:0] ca, cb, cc;
   logic col_end, page_end;

   always_comb begin
      ca = pixel_in[17:12];
      cb = pixel_in[11:6];
      cc = pixel_in[5:0];
      if (scan_reg[SOSC_BIT_BGR])
         pix_next = {cc, cb, ca};
      else
         pix_next = {ca, cb, cc};
      // idle keeps only the top bit of each
      if (idle_reg)
         pix_next = pix_next & {{1'b1, 5'h00}, {1'b1, 5'h00}, {1'b1, 5'h00}};
   end

   always_comb begin
      page_next = page_reg;
      col_next = col_reg;
      col_end = scan_reg[SOSC_BIT_COL_ORDER] ? (col_reg == 9'h000) : (col_reg == LAST_COL);
      page_end = scan_reg[SOSC_BIT_PAGE_ORDER] ? (page_reg == 9'h000) : (page_reg == LAST_PAGE);
      if (pix_step) begin
         // inner counter wraps and steps the outer
         if (!scan_reg[SOSC_BIT_EXCHANGE]) begin
            col_next = sosc_step(col_reg, scan_reg[SOSC_BIT_COL_ORDER], LAST_COL);
            if (col_end)
               page_next = sosc_step(page_reg, scan_reg[SOSC_BIT_PAGE_ORDER], LAST_PAGE);
         end else begin
            page_next = sosc_step(page_reg, scan_reg[SOSC_BIT_PAGE_ORDER], LAST_PAGE);
            if (page_end)
               col_next = sosc_step(col_reg, scan_reg[SOSC_BIT_COL_ORDER], LAST_COL);
         end
      end
      // scroll origin on the refresh side
      if (scan_reg[SOSC_BIT_REFRESH])
         first_next = LAST_PAGE - scroll_reg;
      else
         first_next = scroll_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_reg <= '0;
         page_reg <= 9'h000;
         col_reg <= 9'h000;
         first_reg <= 9'h000;
      end else begin
         pix_reg <= pix_next;
         page_reg <= page_next;
         col_reg <= col_next;
         first_reg <= first_next;
      end
   end

   assign scan_ctrl = scan_reg;
   assign scroll_origin_line = scroll_reg;
   assign idle_mode = idle_reg;
   assign pixel_out = pix_reg;
   assign page_addr = page_reg;
   assign col_addr = col_reg;
   assign first_panel_line = first_reg;

   scan_update_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_par && state_reg == SOSC_ST_SCAN_P1) |=> scan_reg == $past(bif.data))
      else $error("scan setting not updated");
   scan_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(is_par && state_reg == SOSC_ST_SCAN_P1) |=> $stable(scan_reg))
      else $error("scan setting changed without parameter");
   scan_other_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_par && state_reg == SOSC_ST_SCAN_P1) |=> $stable(idle_reg) && $stable(scroll_reg))
      else $error("scan command touched other state");
   scroll_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_par && state_reg == SOSC_ST_SCROLL_P2) |=> scroll_reg == {$past(hi_reg), $past(bif.data)})
      else $error("scroll pointer assembled wrong");
   scroll_partial_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_cmd && bif.data == SOSC_CMD_SCROLL && partial_mode) |=> state_reg == SOSC_ST_IDLE)
      else $error("scroll accepted in partial mode");
   idle_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_cmd && bif.data == SOSC_CMD_IDLE_EXIT) |=> !idle_reg && $stable(scan_reg))
      else $error("idle exit failed");
   swrst_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (is_cmd && bif.data == SOSC_CMD_SW_RESET) |=> scroll_reg == 9'h000 && !idle_reg)
      else $error("software reset incomplete");
   idle_pixel_a: assert property (@(posedge clk) disable iff (!rst_n)
      idle_reg |=> (pix_reg & 18'h1F7DF) == 18'h00000)
      else $error("idle pixel has low bits");
   col_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pix_step && !scan_reg[5] && !scan_reg[6] && col_reg == LAST_COL) |=> col_reg == 9'h000)
      else $error("column did not wrap");

   scan_cmd_c: cover property (@(posedge clk) is_par && state_reg == SOSC_ST_SCAN_P1);
   scroll_cmd_c: cover property (@(posedge clk) is_par && state_reg == SOSC_ST_SCROLL_P2);
   idle_exit_c: cover property (@(posedge clk) idle_reg ##1 !idle_reg);
endmodule : sosc_cmd_top
`default_nettype wire

// file: testbench/sosc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sosc_host_model (
   input wire logic clk,
   output logic write_strobe_n,
   output logic cmd_param_select,
   output logic [7:0] data_in
);
   initial begin
      write_strobe_n = 1'b1;
      cmd_param_select = 1'b1;
      data_in = 8'h00;
   end
   task automatic put_byte(input logic sel, input logic [7:0] val);
      @(posedge clk);
      #2;
      cmd_param_select = sel;
      data_in = val;
      write_strobe_n = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      write_strobe_n = 1'b1;
      repeat (2) @(posedge clk);
      #2;
      // released bus must not look like the last byte
      data_in = ~val;
   endtask : put_byte
   task automatic send_scan(input logic [7:0] p);
      put_byte(1'b0, 8'h36);
      put_byte(1'b1, p & 8'hFB);
   endtask : send_scan
   task automatic send_scroll(input logic [8:0] v);
      put_byte(1'b0, 8'h37);
      put_byte(1'b1, {7'h00, v[8]});
      put_byte(1'b1, v[7:0]);
   endtask : send_scroll
endmodule : sosc_host_model
`default_nettype wire

// file: testbench/scan_order_scroll_idle_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none
module scan_order_scroll_idle_cmds_test;
   import sosc_pkg::*;
   localparam int PAGES_N = 432;
   logic clk, arst_n, write_strobe_n, cmd_param_select, partial_mode, pix_step;
   logic [7:0] data_in, scan_ctrl;
   logic [SOSC_PIX_W-1:0] pixel_in, pixel_out;
   logic [8:0] scroll_origin_line, page_addr, col_addr, first_panel_line;
   logic idle_mode;
   logic [31:0] seed;
   int bad_count, num_checks, scan_m, scroll_m, idle_m;
   always #25 clk = ~clk;
   sosc_host_model u_host (.clk(clk), .write_strobe_n(write_strobe_n),
      .cmd_param_select(cmd_param_select), .data_in(data_in));
   sosc_cmd_top #(.PAGES(PAGES_N), .COLS(240)) u_dut (.clk(clk), .arst_n(arst_n),
      .write_strobe_n(write_strobe_n), .cmd_param_select(cmd_param_select),
      .data_in(data_in), .partial_mode(partial_mode), .pixel_in(pixel_in),
      .pix_step(pix_step), .scan_ctrl(scan_ctrl), .scroll_origin_line(scroll_origin_line),
      .idle_mode(idle_mode), .pixel_out(pixel_out), .page_addr(page_addr),
      .col_addr(col_addr), .first_panel_line(first_panel_line));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pix(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_pix
   task automatic check_state;
      int fl;
      repeat (3) @(posedge clk);
      #1;
      fl = scan_m[4] ? PAGES_N - 1 - scroll_m : scroll_m;
      chk_reg({1'b0, scan_ctrl}, scan_m[8:0]);
      chk_reg(scroll_origin_line, scroll_m[8:0]);
      chk_reg({8'h00, idle_mode}, idle_m[8:0]);
      chk_reg(first_panel_line, fl[8:0]);
   endtask : check_state
   task automatic pix_check;
      logic [17:0] e;
      seed = xs(seed);
      @(posedge clk);
      #2;
      pixel_in = seed[17:0];
      e = scan_m[3] ? {seed[5:0], seed[11:6], seed[17:12]} : seed[17:0];
      if (idle_m != 0) e = e & 18'h20820;
      repeat (2) @(posedge clk);
      #1;
      chk_pix(pixel_out, e);
   endtask : pix_check
   task automatic hw_reset;
      @(posedge clk);
      #2;
      arst_n = 1'b0;
      repeat (12) @(posedge clk);
      #2;
      arst_n = 1'b1;
      scan_m = 0;
      scroll_m = 0;
      idle_m = 0;
      repeat (4) @(posedge clk);
   endtask : hw_reset
   initial begin
      #(50 * 30000);
      bad_count++;
      give_verdict();
   end
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      partial_mode = 1'b0;
      pixel_in = '0;
      pix_step = 1'b0;
      seed = 32'd26870;
      bad_count = 0;
      num_checks = 0;
      hw_reset();
      check_state();
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         scan_m = {24'h0, seed[7:0] & 8'hFB};
         u_host.send_scan(seed[7:0]);
         check_state();
         pix_check();
         seed = xs(seed);
         partial_mode = (i == 3);
         if (i != 3) scroll_m = seed[8:0] % PAGES_N;
         u_host.send_scroll(9'(seed[8:0] % PAGES_N));
         check_state();
         partial_mode = 1'b0;
      end
      u_host.put_byte(1'b0, SOSC_CMD_IDLE_ENTER);
      idle_m = 1;
      check_state();
      pix_check();
      u_host.put_byte(1'b0, SOSC_CMD_IDLE_EXIT);
      idle_m = 0;
      check_state();
      u_host.put_byte(1'b0, SOSC_CMD_IDLE_EXIT);
      check_state();
      u_host.put_byte(1'b0, SOSC_CMD_IDLE_ENTER);
      u_host.put_byte(1'b0, SOSC_CMD_SW_RESET);
      scroll_m = 0;
      check_state();
      hw_reset();
      check_state();
      repeat (3) begin
         @(posedge clk);
         #2;
         pix_step = 1'b1;
         @(posedge clk);
         #2;
         pix_step = 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
      chk_reg(col_addr, 9'h003);
      chk_reg(page_addr, 9'h000);
      // exchanged ordering: page counter now moves first
      u_host.send_scan(8'h20);
      scan_m = 32'h20;
      check_state();
      repeat (3) begin
         @(posedge clk);
         #2;
         pix_step = 1'b1;
         @(posedge clk);
         #2;
         pix_step = 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
      chk_reg(page_addr, 9'h003);
      chk_reg(col_addr, 9'h003);
      give_verdict();
   end
endmodule : scan_order_scroll_idle_cmds_test
`default_nettype wire
